// *** rtl/ctm_top.v ***
// Compact timer module: AXI4-Lite register file, 10-bit up counter with
// period and compare-A comparators, compare-output and PWM pin logic.
// Assumes one 20 MHz clock; low oscillator arrives as a one-cycle tick.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "ctm_defs.vh"

module ctm_top
(
	input  wire        mclk_i,
	input  wire        rstn_i,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        lirc_tick_i,
	input  wire        ext_count_pin_i,
	output reg         timer_out_pin_first_o,
	output reg         timer_out_pin_first_en_o,
	output reg         timer_out_pin_second_o,
	output reg         timer_out_pin_second_en_o,
	output reg         match_a_flag_o,
	output reg         match_p_flag_o
);

	// ==========================================================
	// Register state
	reg  [3:0]  pin_en_r;
	reg  [7:0]  ctrl0_r;
	reg  [7:0]  ctrl1_r;
	reg  [9:0]  cmpa_r;
	reg  [7:0]  byte_buf_r;
	reg  [1:0]  flags_r;
	reg  [9:0]  cnt_r;
	reg         on_d_r;
	reg         cmp_lvl_r;
	reg         pwm_act_r;

	reg  [7:0]  aw_addr_r;
	reg         aw_have_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;
	reg         w_have_r;

	// ==========================================================
	// Field views
	wire        pause_ctl         = ctrl0_r[`CTM_C0_PAUSE];
	wire [2:0]  count_clk_sel     = ctrl0_r[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
	wire        timer_on          = ctrl0_r[`CTM_C0_ON];
	wire [2:0]  period_value      = ctrl0_r[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
	wire [1:0]  op_mode_sel       = ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
	wire [1:0]  out_action_sel    = ctrl1_r[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
	wire        out_initial_level = ctrl1_r[`CTM_C1_INIT];
	wire        out_invert        = ctrl1_r[`CTM_C1_INV];
	wire        period_duty_swap  = ctrl1_r[`CTM_C1_SWAP];
	wire        clear_source_sel  = ctrl1_r[`CTM_C1_CLRSEL];

	wire        mode_pwm = (op_mode_sel == `CTM_MODE_PWM);
	wire        mode_cmp = (op_mode_sel == `CTM_MODE_CMP);

	// ==========================================================
	// Count clock source
	wire        tick;

	ctm_clk_sel u_clk_sel
	(
		.mclk_i          (mclk_i),
		.rstn_i          (rstn_i),
		.sel_i           (count_clk_sel),
		.lirc_tick_i     (lirc_tick_i),
		.ext_count_pin_i (ext_count_pin_i),
		.tick_o          (tick)
	);

	// ==========================================================
	// Comparators
	wire        on_rise  = timer_on & ~on_d_r;
	wire        step     = timer_on & ~pause_ctl & tick;
	wire [10:0] cnt_inc  = {1'b0, cnt_r} + 11'h001;
	wire        ovf      = cnt_inc[10];
	// Match is taken on the value the counter is about to reach
	wire        p_hit    = (period_value == 3'h0) ? ovf :
	                       ((cnt_inc[9:7] == period_value) && (cnt_inc[6:0] == 7'h00));
	wire        a_hit    = (cmpa_r != 10'h000) && !ovf && (cnt_inc[9:0] == cmpa_r);
	wire        a_period = a_hit | ((cmpa_r == 10'h000) & ovf);

	wire        use_a_clear = mode_pwm ? period_duty_swap : clear_source_sel;
	wire        clr_hit     = use_a_clear ? a_period : p_hit;
	// With clearing on A, the period flag is never raised outside PWM
	wire        p_flag_hit  = p_hit & (mode_pwm | ~clear_source_sel);

	// ==========================================================
	// PWM period and duty in ticks
	wire [10:0] rp_ticks  = (period_value == 3'h0) ? `CTM_FULL_COUNT :
	                        ({8'h00, period_value} * `CTM_P_STEP);
	wire [10:0] a_ticks   = {1'b0, cmpa_r};
	wire [10:0] a_per     = (cmpa_r == 10'h000) ? `CTM_FULL_COUNT : a_ticks;
	wire [10:0] per_ticks = period_duty_swap ? a_per : rp_ticks;
	wire [10:0] duty_ticks = period_duty_swap ? rp_ticks : a_ticks;
	wire        duty_full = (duty_ticks >= per_ticks);
	wire        duty_hit  = period_duty_swap ? p_hit : a_hit;
	wire        act_start = duty_full | (duty_ticks != 11'h000);

	// ==========================================================
	// Counter, output state, flags
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_r          <= 10'h000;
			on_d_r         <= 1'b0;
			cmp_lvl_r      <= 1'b0;
			pwm_act_r      <= 1'b0;
			match_a_flag_o <= 1'b0;
			match_p_flag_o <= 1'b0;
		end
		else
		begin
			on_d_r         <= timer_on;
			match_a_flag_o <= step & a_hit;
			match_p_flag_o <= step & p_flag_hit;
			if (on_rise)
			begin
				cnt_r     <= 10'h000;
				cmp_lvl_r <= out_initial_level;
				pwm_act_r <= act_start;
			end
			else if (step)
			begin
				// Overflow wraps to zero through the dropped carry
				cnt_r <= clr_hit ? 10'h000 : cnt_inc[9:0];
				if (mode_cmp && a_hit)
				begin
					case (out_action_sel)
						`CTM_ACT_LOW:    cmp_lvl_r <= 1'b0;
						`CTM_ACT_HIGH:   cmp_lvl_r <= 1'b1;
						`CTM_ACT_TOGGLE: cmp_lvl_r <= ~cmp_lvl_r;
						default:         cmp_lvl_r <= cmp_lvl_r;
					endcase
				end
				if (clr_hit)
					pwm_act_r <= act_start;
				else if (duty_hit)
					pwm_act_r <= duty_full;
			end
		end
	end

	// ==========================================================
	// Pin drive
	reg         pwm_lvl;
	reg         pin_lvl;
	wire        pin_used = mode_cmp | mode_pwm;

	always @*
	begin
		case (out_action_sel)
			`CTM_PWM_ACTIVE: pwm_lvl = out_initial_level;
			`CTM_PWM_WAVE:   pwm_lvl = pwm_act_r ? out_initial_level : ~out_initial_level;
			default:         pwm_lvl = ~out_initial_level;
		endcase
		if (mode_pwm)
			pin_lvl = pwm_lvl ^ out_invert;
		else if (mode_cmp)
			pin_lvl = cmp_lvl_r ^ out_invert;
		else
			pin_lvl = 1'b0;
	end

	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			timer_out_pin_first_o     <= 1'b0;
			timer_out_pin_second_o    <= 1'b0;
			timer_out_pin_first_en_o  <= 1'b0;
			timer_out_pin_second_en_o <= 1'b0;
		end
		else
		begin
			timer_out_pin_first_o     <= pin_lvl;
			timer_out_pin_second_o    <= pin_lvl;
			timer_out_pin_first_en_o  <= pin_en_r[0] & pin_used;
			timer_out_pin_second_en_o <= pin_en_r[1] & pin_used;
		end
	end

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;

	wire        wr_go  = aw_have_r & w_have_r & ~s_axi_bvalid;
	wire        wr_lane = w_strb_r[0];
	wire [7:0]  wr_byte = w_data_r[7:0];
	wire        wr_map = (aw_addr_r[7:5] == 3'h0) && (aw_addr_r[1:0] == 2'h0);

	// ==========================================================
	// AXI4-Lite read path
	assign s_axi_arready = ~s_axi_rvalid;

	wire        rd_go  = s_axi_arvalid & ~s_axi_rvalid;
	wire        rd_map = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
	reg  [7:0]  rd_byte;

	always @*
	begin
		case (s_axi_araddr)
			`CTM_OFS_PIN_EN:  rd_byte = {4'h0, pin_en_r};
			`CTM_OFS_CTRL0:   rd_byte = ctrl0_r;
			`CTM_OFS_CTRL1:   rd_byte = ctrl1_r;
			`CTM_OFS_CNT_LO:  rd_byte = byte_buf_r;
			`CTM_OFS_CNT_HI:  rd_byte = {6'h00, cnt_r[9:8]};
			`CTM_OFS_CMPA_LO: rd_byte = byte_buf_r;
			`CTM_OFS_CMPA_HI: rd_byte = {6'h00, cmpa_r[9:8]};
			`CTM_OFS_FLAGS:   rd_byte = {6'h00, flags_r};
			default:          rd_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// Register file and bus handshake
	wire        wr_flags = wr_go & wr_lane & (aw_addr_r == `CTM_OFS_FLAGS);
	wire [1:0]  flag_set = {match_p_flag_o, match_a_flag_o};
	wire [1:0]  flag_clr = wr_flags ? wr_byte[1:0] : 2'h0;

	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_en_r     <= `CTM_RST_PIN_EN;
			ctrl0_r      <= `CTM_RST_CTRL0;
			ctrl1_r      <= `CTM_RST_CTRL1;
			cmpa_r       <= 10'h000;
			byte_buf_r   <= 8'h00;
			flags_r      <= 2'h0;
			aw_addr_r    <= 8'h00;
			aw_have_r    <= 1'b0;
			w_data_r     <= 32'h00000000;
			w_strb_r     <= 4'h0;
			w_have_r     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CTM_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `CTM_RESP_OKAY;
		end
		else
		begin
			// Sticky match flags; a new match beats a same-cycle clear
			flags_r <= (flags_r & ~flag_clr) | flag_set;

			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_r <= s_axi_awaddr;
				aw_have_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				w_have_r <= 1'b1;
			end

			if (wr_go)
			begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
				if (wr_lane)
				begin
					case (aw_addr_r)
						`CTM_OFS_PIN_EN:  pin_en_r <= wr_byte[3:0];
						`CTM_OFS_CTRL0:   ctrl0_r  <= wr_byte;
						`CTM_OFS_CTRL1:   ctrl1_r  <= wr_byte;
						`CTM_OFS_CMPA_LO: byte_buf_r <= wr_byte;
						`CTM_OFS_CMPA_HI: cmpa_r   <= {wr_byte[1:0], byte_buf_r};
						default:          pin_en_r <= pin_en_r;
					endcase
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;

			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_byte};
				s_axi_rresp  <= rd_map ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
				// Shared buffer; a write to the compare low byte in the same
				// cycle loses to the read latch, software must not mix them
				if (s_axi_araddr == `CTM_OFS_CNT_HI)
					byte_buf_r <= cnt_r[7:0];
				else if (s_axi_araddr == `CTM_OFS_CMPA_HI)
					byte_buf_r <= cmpa_r[7:0];
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// *** shared/ctm_defs.vh ***
// Constants for the compact timer module: register byte offsets, control
// field positions, reset values, mode and action codes, prescaler ratios.
// Assumes inclusion by bare name from the design files.
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// ==========================================================
// Register byte addresses (one aligned 32-bit word each)
`define CTM_OFS_PIN_EN     8'h00
`define CTM_OFS_CTRL0      8'h04
`define CTM_OFS_CTRL1      8'h08
`define CTM_OFS_CNT_LO     8'h0c
`define CTM_OFS_CNT_HI     8'h10
`define CTM_OFS_CMPA_LO    8'h14
`define CTM_OFS_CMPA_HI    8'h18
`define CTM_OFS_FLAGS      8'h1c

// ==========================================================
// Reset values
`define CTM_RST_PIN_EN     4'h5
`define CTM_RST_CTRL0      8'h00
`define CTM_RST_CTRL1      8'h00

// ==========================================================
// Control 0 fields
`define CTM_C0_PAUSE       7
`define CTM_C0_CKSEL_HI    6
`define CTM_C0_CKSEL_LO    4
`define CTM_C0_ON          3
`define CTM_C0_RP_HI       2
`define CTM_C0_RP_LO       0

// ==========================================================
// Control 1 fields
`define CTM_C1_MODE_HI     7
`define CTM_C1_MODE_LO     6
`define CTM_C1_ACT_HI      5
`define CTM_C1_ACT_LO      4
`define CTM_C1_INIT        3
`define CTM_C1_INV         2
`define CTM_C1_SWAP        1
`define CTM_C1_CLRSEL      0

// ==========================================================
// Operating modes and output actions
`define CTM_MODE_CMP       2'h0
`define CTM_MODE_PWM       2'h2
`define CTM_MODE_TMR       2'h3
`define CTM_ACT_NONE       2'h0
`define CTM_ACT_LOW        2'h1
`define CTM_ACT_HIGH       2'h2
`define CTM_ACT_TOGGLE     2'h3
`define CTM_PWM_INACTIVE   2'h0
`define CTM_PWM_ACTIVE     2'h1
`define CTM_PWM_WAVE       2'h2

// ==========================================================
// Count clock selector codes and prescaler ratios
`define CTM_CK_SYS4        3'h0
`define CTM_CK_SYS         3'h1
`define CTM_CK_H16         3'h2
`define CTM_CK_H64         3'h3
`define CTM_CK_LIRC        3'h4
`define CTM_CK_OFF         3'h5
`define CTM_CK_EXT_RISE    3'h6
`define CTM_CK_EXT_FALL    3'h7
`define CTM_DIV4_MASK      6'h03
`define CTM_DIV16_MASK     6'h0f
`define CTM_DIV64_MASK     6'h3f

// ==========================================================
// Counter geometry
`define CTM_P_STEP         11'h080
`define CTM_FULL_COUNT     11'h400

// ==========================================================
// AXI responses
`define CTM_RESP_OKAY      2'h0
`define CTM_RESP_SLVERR    2'h2

`endif

// *** rtl/ctm_clk_sel.v ***
// Count clock selector: turns the chosen source into a one-cycle tick on mclk.
// Assumes lirc_tick_i is already a one-cycle enable and the pin is synchronous.
`timescale 1ns/1ns
`include "ctm_defs.vh"

module ctm_clk_sel
(
	input  wire       mclk_i,
	input  wire       rstn_i,
	input  wire [2:0] sel_i,
	input  wire       lirc_tick_i,
	input  wire       ext_count_pin_i,
	output reg        tick_o
);

	reg  [5:0] pre_r;
	reg        ext_d_r;
	wire       ext_rise;
	wire       ext_fall;

	// ==========================================================
	// Free-running prescaler; the high internal clock is mclk here
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pre_r   <= 6'h00;
			ext_d_r <= 1'b0;
		end
		else
		begin
			pre_r   <= pre_r + 6'h01;
			ext_d_r <= ext_count_pin_i;
		end
	end

	assign ext_rise = ext_count_pin_i & ~ext_d_r;
	assign ext_fall = ~ext_count_pin_i & ext_d_r;

	// ==========================================================
	// Source select
	always @*
	begin
		case (sel_i)
			`CTM_CK_SYS4:     tick_o = ((pre_r & `CTM_DIV4_MASK) == `CTM_DIV4_MASK);
			`CTM_CK_SYS:      tick_o = 1'b1;
			`CTM_CK_H16:      tick_o = ((pre_r & `CTM_DIV16_MASK) == `CTM_DIV16_MASK);
			`CTM_CK_H64:      tick_o = (pre_r == `CTM_DIV64_MASK);
			`CTM_CK_LIRC:     tick_o = lirc_tick_i;
			`CTM_CK_EXT_RISE: tick_o = ext_rise;
			`CTM_CK_EXT_FALL: tick_o = ext_fall;
			default:          tick_o = 1'b0;
		endcase
	end

endmodule

// *** sim/ctm_pin_model.sv ***
// Far-side model: external count pin and low oscillator tick source.
// Assumes the bench clock; both outputs change just after rising edges.
`timescale 1ns/1ns
module ctm_pin_model
(
	input  wire mclk_i,
	input  wire rstn_i,
	output wire ext_pin_o,
	output wire lirc_tick_o
);
// ==========================================================
// Sources
reg [1:0] cnt_r;
// A four-clock pin period gives one rising and one falling edge per source period
assign ext_pin_o   = cnt_r[1];
assign lirc_tick_o = &cnt_r;
always @(posedge mclk_i or negedge rstn_i)
	if (!rstn_i)
		cnt_r <= 2'h0;
	else
		cnt_r <= cnt_r + 2'h1;
endmodule

// *** sim/ctm_monitor.sv ***
// Checker for the timer: bus handshakes, read data shape, pins and flag pulses.
// Assumes it is bound to ctm_top and sees only its ports.
`timescale 1ns/1ns
module ctm_monitor
(
	input wire        mclk_i,
	input wire        rstn_i,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        timer_out_pin_first_o,
	input wire        timer_out_pin_first_en_o,
	input wire        timer_out_pin_second_o,
	input wire        match_a_flag_o,
	input wire        match_p_flag_o
);
default clocking mon_cb @(posedge mclk_i);
endclocking
default disable iff (!rstn_i);
// ==========================================================
// Register bus
b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
	else $error("write response withdrawn");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read data withdrawn");
w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write taken while response pending");
r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken while data pending");
w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
	|-> ##2 s_axi_bvalid) else $error("write response late");
r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read data late");
r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
	else $error("read data upper bits set");
// ==========================================================
// Timer outputs
pin_same_a: assert property (timer_out_pin_first_o == timer_out_pin_second_o)
	else $error("output pins differ");
a_pulse_a: assert property (match_a_flag_o |=> !match_a_flag_o)
	else $error("match a flag longer than one cycle");
p_pulse_a: assert property (match_p_flag_o |=> !match_p_flag_o)
	else $error("match p flag longer than one cycle");
cov_a: cover property (match_a_flag_o);
cov_p: cover property (match_p_flag_o);
cov_pin: cover property (timer_out_pin_first_en_o && timer_out_pin_first_o);
endmodule
bind ctm_top ctm_monitor u_mon
(
	.mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.timer_out_pin_first_o(timer_out_pin_first_o),
	.timer_out_pin_first_en_o(timer_out_pin_first_en_o),
	.timer_out_pin_second_o(timer_out_pin_second_o),
	.match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o)
);

// *** sim/testbench.sv ***
// Testbench: drives the timer over AXI4-Lite, judges pins, flags and registers.
// Assumes ctm_top, the pin model and the bound monitor are compiled first.
`timescale 1ns/1ns
`include "ctm_defs.vh"
module testbench;
// ==========================================================
// Signals
reg         mclk_i = 1'b0;
reg         rstn_i = 1'b0;
reg  [7:0]  awaddr = 8'h00;
reg  [7:0]  araddr = 8'h00;
reg  [31:0] wdata = 32'h0;
reg         awvalid = 1'b0;
reg         wvalid = 1'b0;
reg         bready = 1'b0;
reg         arvalid = 1'b0;
reg         rready = 1'b0;
wire        awready, wready, bvalid, arready, rvalid;
wire [1:0]  bresp, rresp;
wire [31:0] rdata;
wire        ext_pin, lirc, p0, p0e, p1, p1e, mfa, mfp;
integer     num_errors = 0;
integer     num_checks = 0;
reg  [1:0]  wr_resp = 2'h0;
always #25 mclk_i = ~mclk_i;
ctm_pin_model u_far (.mclk_i(mclk_i), .rstn_i(rstn_i), .ext_pin_o(ext_pin), .lirc_tick_o(lirc));
ctm_top u_dut
(
	.mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
	.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
	.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
	.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
	.lirc_tick_i(lirc), .ext_count_pin_i(ext_pin), .timer_out_pin_first_o(p0),
	.timer_out_pin_first_en_o(p0e), .timer_out_pin_second_o(p1),
	.timer_out_pin_second_en_o(p1e), .match_a_flag_o(mfa), .match_p_flag_o(mfp)
);
// ==========================================================
// Shared tasks
task chk(input logic ok, input string m);
	num_checks++;
	if (ok !== 1'b1)
	begin
		num_errors++;
		$display("[FAIL] %0t %s", $time, m);
	end
endtask
task wr(input [7:0] a, input [7:0] d);
	reg ta, tw, tb;
	@(posedge mclk_i);
	awaddr <= a;
	wdata <= {24'h0, d};
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	tb = 1'b0;
	for (int n = 0; n < 40 && !tb; n++)
	begin
		@(negedge mclk_i);
		ta = awvalid && awready;
		tw = wvalid && wready;
		tb = bvalid && bready;
		if (tb) wr_resp = bresp;
		@(posedge mclk_i);
		if (ta) awvalid <= 1'b0;
		if (tw) wvalid <= 1'b0;
		if (tb) bready <= 1'b0;
	end
	chk(tb, "write hung");
endtask
task rd(input [7:0] a, output [31:0] d, output [1:0] r);
	reg ta, tr;
	@(posedge mclk_i);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	tr = 1'b0;
	for (int n = 0; n < 40 && !tr; n++)
	begin
		@(negedge mclk_i);
		ta = arvalid && arready;
		tr = rvalid && rready;
		d = rdata;
		r = rresp;
		@(posedge mclk_i);
		if (ta) arvalid <= 1'b0;
		if (tr) rready <= 1'b0;
	end
	chk(tr, "read hung");
endtask
task rcnt(output [9:0] v);
	reg [31:0] d;
	reg [1:0]  r;
	rd(`CTM_OFS_CNT_HI, d, r);
	v[9:8] = d[1:0];
	rd(`CTM_OFS_CNT_LO, d, r);
	v[7:0] = d[7:0];
endtask
// Timer is switched off before control 1 changes, as software must
task cfg(input [7:0] c1, input [7:0] c0);
	wr(`CTM_OFS_CTRL0, 8'h00);
	wr(`CTM_OFS_CTRL1, c1);
	wr(`CTM_OFS_CTRL0, c0);
endtask
task seta(input [9:0] v);
	wr(`CTM_OFS_CMPA_LO, v[7:0]);
	wr(`CTM_OFS_CMPA_HI, {6'h0, v[9:8]});
endtask
// Cycles between two pulses of one flag; zero when fewer than two seen in lim cycles
task gap(input bit p, input integer lim, output integer n);
	integer t0;
	t0 = -1;
	n = 0;
	for (int k = 0; k < lim && n == 0; k++)
	begin
		@(negedge mclk_i);
		if ((p ? mfp : mfa) === 1'b1)
		begin
			if (t0 >= 0) n = k - t0;
			t0 = k;
		end
	end
endtask
task await(input bit p);
	integer k;
	for (k = 0; k < 3000 && (p ? mfp : mfa) !== 1'b1; k++)
		@(negedge mclk_i);
	chk(k < 3000, "flag pulse missing");
endtask
// ==========================================================
// Scenarios
task t_regs;
	reg [31:0] d;
	reg [1:0]  r;
	for (int i = 0; i < 7; i++)
	begin
		rd(8'(i * 4), d, r);
		chk(d === (i == 0 ? 32'h5 : 32'h0) && r === `CTM_RESP_OKAY, "reset value");
	end
	rd(8'h20, d, r);
	chk(r === `CTM_RESP_SLVERR && d === 32'h0, "unmapped read");
	wr(8'h20, 8'h11);
	chk(wr_resp === `CTM_RESP_SLVERR, "unmapped write response");
	wr(`CTM_OFS_CNT_LO, 8'hff);
	chk(wr_resp === `CTM_RESP_OKAY, "read-only write response");
	rd(`CTM_OFS_CNT_HI, d, r);
	rd(`CTM_OFS_CNT_LO, d, r);
	chk(d === 32'h0, "count written");
endtask
task t_buf;
	reg [31:0] d;
	reg [1:0]  r;
	wr(`CTM_OFS_CMPA_LO, 8'h34);
	rd(`CTM_OFS_CMPA_HI, d, r);
	rd(`CTM_OFS_CMPA_LO, d, r);
	chk(d === 32'h0, "low byte committed early");
	seta(10'h234);
	rd(`CTM_OFS_CMPA_HI, d, r);
	chk(d === 32'h2, "compare high");
	rd(`CTM_OFS_CMPA_LO, d, r);
	chk(d === 32'h34, "compare low");
endtask
task t_count;
	reg [9:0] v1, v2, v3, v4;
	// Pin control off while timer/counter mode runs
	wr(`CTM_OFS_PIN_EN, 8'h00);
	cfg(8'hc0, 8'h18);
	repeat (300) @(posedge mclk_i);
	wr(`CTM_OFS_CTRL0, 8'h98);
	rcnt(v1);
	repeat (20) @(posedge mclk_i);
	rcnt(v2);
	chk(v1 === v2 && v1 > 10'd290, "pause");
	wr(`CTM_OFS_CTRL0, 8'h18);
	repeat (30) @(posedge mclk_i);
	wr(`CTM_OFS_CTRL0, 8'h10);
	rcnt(v3);
	chk(v3 > v2 + 10'd29 && v3 < v2 + 10'd45, "resume");
	repeat (20) @(posedge mclk_i);
	rcnt(v4);
	chk(v4 === v3, "off keeps count");
	wr(`CTM_OFS_CTRL0, 8'h18);
	wr(`CTM_OFS_CTRL0, 8'h10);
	rcnt(v4);
	chk(v4 < 10'd10, "on rise clears");
endtask
task t_clk;
	integer ex[8] = '{512, 128, 2048, 8192, 512, 0, 512, 512};
	integer n;
	reg [31:0] d;
	reg [1:0]  r;
	for (int s = 0; s < 8; s++)
	begin
		cfg(8'hc0, {1'b0, 3'(s), 4'h9});
		gap(1, 17000, n);
		chk(n === ex[s], "period per clock source");
	end
	cfg(8'hc0, 8'h18);
	gap(1, 2200, n);
	chk(n === 1024, "overflow period");
	cfg(8'hc1, 8'h19);
	gap(1, 1500, n);
	chk(n === 0, "p flag with a clear");
	gap(0, 1500, n);
	chk(n >= 564 && n <= 565, "a clear period");
	// Both flags have fired by now and nothing has cleared them
	wr(`CTM_OFS_CTRL0, 8'h00);
	rd(`CTM_OFS_FLAGS, d, r);
	chk(d === 32'h3, "sticky flags");
	wr(`CTM_OFS_FLAGS, 8'h01);
	rd(`CTM_OFS_FLAGS, d, r);
	chk(d === 32'h2, "flag clear");
endtask
task t_cmp;
	reg [7:0] c1[6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h2c, 8'h38};
	reg       bf[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	reg       af[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	wr(`CTM_OFS_PIN_EN, 8'h03);
	seta(10'h010);
	for (int i = 0; i < 6; i++)
	begin
		cfg(c1[i], 8'h19);
		repeat (4) @(negedge mclk_i);
		chk(p0 === bf[i] && p0e === 1'b1 && p1e === 1'b1, "initial pin");
		await(0);
		repeat (3) @(negedge mclk_i);
		chk(p0 === af[i] && p1 === af[i], "pin after a match");
		await(1);
		repeat (3) @(negedge mclk_i);
		chk(p0 === af[i], "pin after p match");
	end
	wr(`CTM_OFS_PIN_EN, 8'h01);
	repeat (3) @(negedge mclk_i);
	chk(p0e === 1'b1 && p1e === 1'b0, "pin enable");
	cfg(8'hc0, 8'h19);
	repeat (3) @(negedge mclk_i);
	chk(p0e === 1'b0, "timer mode pin");
	wr(`CTM_OFS_PIN_EN, 8'h03);
endtask
task t_pwm;
	reg [9:0] av[7] = '{10'd32, 10'd200, 10'd32, 10'd32, 10'd32, 10'd32, 10'd256};
	reg [7:0] c1[7] = '{8'ha9, 8'ha8, 8'h88, 8'h98, 8'ha0, 8'hac, 8'haa};
	integer   ex[7] = '{128, 512, 0, 512, 384, 384, 256};
	integer   h;
	// Last case swaps roles: compare A sets the period, the period field the duty
	for (int i = 0; i < 7; i++)
	begin
		seta(av[i]);
		cfg(c1[i], 8'h19);
		repeat (8) @(negedge mclk_i);
		h = 0;
		repeat (512)
		begin
			@(negedge mclk_i);
			h += (p0 === 1'b1);
		end
		chk(h === ex[i], "pwm high cycles");
	end
endtask
// ==========================================================
// Sequence and verdict
task wrap_up;
	$display("checks %0d errors %0d", num_checks, num_errors);
	if (num_errors == 0 && num_checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
initial
begin
	repeat (4) @(posedge mclk_i);
	rstn_i <= 1'b1;
	t_regs;
	t_buf;
	t_count;
	t_clk;
	t_cmp;
	t_pwm;
	wrap_up;
end
initial
begin
	#4000000;
	num_errors++;
	wrap_up;
end
endmodule
